// >>> common/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] dir_f_offset = 8'h04;
  localparam logic [7:0] out_f_offset = 8'h08;
  localparam logic [7:0] dir_g_offset = 8'h0c;
  localparam logic [7:0] out_g_offset = 8'h10;
  localparam logic [7:0] dir_h_offset = 8'h14;
  localparam logic [7:0] out_h_offset = 8'h18;
  localparam logic [7:0] pin_in_offset = 8'h1c;
  localparam logic [7:0] pad_dir_offset = 8'h20;
  localparam logic [7:0] pad_pu_offset = 8'h24;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int ctrl_debug_bit = 0;
  localparam int ctrl_async_bit = 1;
  localparam int ctrl_extclk_bit = 2;
  localparam int ctrl_extmem_bit = 3;
  localparam int ctrl_pud_bit = 4;
  localparam logic [4:0] ctrl_reset = 5'h00;
  localparam logic [7:0] port_reset = 8'h00;

  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int pf_tdi = 7;
  localparam int pf_tdo = 6;
  localparam int pf_tms = 5;
  localparam int pf_tck = 4;
  localparam int pg_t0_compare_b_out = 5;
  localparam int pg_osc_in = 4;
  localparam int pg_osc_out = 3;
  localparam int pg_ale = 2;
  localparam int pg_rd = 1;
  localparam int pg_wr = 0;
  localparam int ph_t4 = 7;
  localparam int ph_t2_compare_b_out = 6;
  localparam int ph_t4_compare_c_out = 5;
  localparam int ph_t4_compare_b_out = 4;

endpackage

// >>> hdl/pin_input_sync.sv
`timescale 1ns/1ps
module pin_input_sync #(
  parameter int width = 24
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] sync_o
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] next_stage1;
  logic [width-1:0] next_stage2;

  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;
endmodule

// >>> hdl/pin_override_cell.sv
`timescale 1ns/1ps
module pin_override_cell (
  // normal port controls
  input wire logic port_pullup_i,
  input wire logic port_dir_i,
  input wire logic port_value_i,
  input wire logic port_ie_i,
  // override pairs
  input wire logic pullup_override_en_i,
  input wire logic pullup_override_val_i,
  input wire logic direction_override_en_i,
  input wire logic direction_override_val_i,
  input wire logic portvalue_override_en_i,
  input wire logic portvalue_override_val_i,
  input wire logic input_enable_override_en_i,
  input wire logic input_enable_override_val_i,
  // pad controls
  output logic pullup_o,
  output logic dir_o,
  output logic value_o,
  output logic ie_o
);
  // pure mux, no state
  assign pullup_o = pullup_override_en_i ? pullup_override_val_i : port_pullup_i;
  assign dir_o = direction_override_en_i ? direction_override_val_i : port_dir_i;
  assign value_o = portvalue_override_en_i ? portvalue_override_val_i : port_value_i;
  assign ie_o = input_enable_override_en_i ? input_enable_override_val_i : port_ie_i;
endmodule

// >>> hdl/port_fgh_alt_function_override.sv
// Behaviour
// - debug enable takes pull-up, direction, input enable of upper port f pins.
// - debug data out drives only in shift-ir or shift-dr, else tri-stated.
// - debug on: pull-ups on except data out, inputs except data out in shift, input buffers off.
// - lower port f pins have no overrides; analog inputs taken from pin.
// - timer0 compare b replaces pg5 value; direction bit still rules.
// - async select frees pg4: pull-up off, input, input enable from ext clock.
// - pg3 overrides gated by async select and ext clock select together.
// - external memory forces pg2..pg0 outputs, no pull-up, driving strobes.
// - latch strobe captures low address; read and write strobes control access.
// - ph7 digital input feeds timer4 count source, no other override.
// - ph6..ph4 carry t2 compare b, t4 compare c, t4 compare b when enabled.
// - debug pull-ups stay on during reset while debug enable active.
`timescale 1ns/1ps
module port_fgh_alt_function_override
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // debug tap state
  input wire logic tap_shift_ir_i,
  input wire logic tap_shift_dr_i,
  input wire logic tap_tdo_i,
  // timer compare outputs and enables
  input wire logic t0_compare_b_en_i,
  input wire logic t0_compare_b_out_i,
  input wire logic t2_compare_b_en_i,
  input wire logic t2_compare_b_out_i,
  input wire logic t4_compare_c_en_i,
  input wire logic t4_compare_c_out_i,
  input wire logic t4_compare_b_en_i,
  input wire logic t4_compare_b_out_i,
  // external memory strobes
  input wire logic ext_ale_i,
  input wire logic ext_rd_i,
  input wire logic ext_wr_i,
  // pads: input, output, output enable, pull-up, input enable
  input wire logic [7:0] pf_pad_i,
  input wire logic [7:0] pg_pad_i,
  input wire logic [7:0] ph_pad_i,
  output logic [7:0] pf_pad_o,
  output logic [7:0] pf_pad_oe_o,
  output logic [7:0] pf_pullup_o,
  output logic [7:0] pf_ie_o,
  output logic [7:0] pg_pad_o,
  output logic [7:0] pg_pad_oe_o,
  output logic [7:0] pg_pullup_o,
  output logic [7:0] pg_ie_o,
  output logic [7:0] ph_pad_o,
  output logic [7:0] ph_pad_oe_o,
  output logic [7:0] ph_pullup_o,
  output logic [7:0] ph_ie_o,
  // alternate function feeds
  output logic [7:0] analog_in_o,
  output logic [3:0] debug_pins_o,
  output logic timer_osc_in_pin_o,
  output logic t4_count_input_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // known power-on value: reset keeps the debug bit, so it must not start unknown
  logic [4:0] ctrl = ctrl_reset;
  logic [7:0] dir_f, out_f, dir_g, out_g, dir_h, out_h;
  logic [4:0] next_ctrl;
  logic [7:0] next_dir_f, next_out_f, next_dir_g, next_out_g, next_dir_h, next_out_h;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic [23:0] pins_sync;

  logic debug_iface_enable;
  logic timer2_async_select;
  logic ext_clock_input_select;
  logic ext_memory_enable;
  logic pullup_disable;
  assign debug_iface_enable = ctrl[ctrl_debug_bit];
  assign timer2_async_select = ctrl[ctrl_async_bit];
  assign ext_clock_input_select = ctrl[ctrl_extclk_bit];
  assign ext_memory_enable = ctrl[ctrl_extmem_bit];
  assign pullup_disable = ctrl[ctrl_pud_bit];

  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = (a == o);
  endfunction

  // ----------------------------------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // ----------------------------------------------------------------
  logic wr_access;
  logic rd_access;
  logic mapped;
  assign wr_access = psel_i && penable_i && pwrite_i;
  assign rd_access = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign mapped = paddr_i <= pad_pu_offset && paddr_i[1:0] == 2'b00;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_comb begin
    next_ctrl = ctrl;
    next_dir_f = dir_f;
    next_out_f = out_f;
    next_dir_g = dir_g;
    next_out_g = out_g;
    next_dir_h = dir_h;
    next_out_h = out_h;
    next_prdata = prdata;
    if (wr_access) begin
      if (sel(paddr_i, ctrl_offset)) next_ctrl = pwdata_i[4:0];
      if (sel(paddr_i, dir_f_offset)) next_dir_f = pwdata_i[7:0];
      if (sel(paddr_i, out_f_offset)) next_out_f = pwdata_i[7:0];
      if (sel(paddr_i, dir_g_offset)) next_dir_g = pwdata_i[7:0];
      if (sel(paddr_i, out_g_offset)) next_out_g = pwdata_i[7:0];
      if (sel(paddr_i, dir_h_offset)) next_dir_h = pwdata_i[7:0];
      if (sel(paddr_i, out_h_offset)) next_out_h = pwdata_i[7:0];
    end
    if (rd_access) begin
      next_prdata = 32'h0000_0000;
      case (paddr_i)
        ctrl_offset: next_prdata = {27'h0, ctrl};
        dir_f_offset: next_prdata = {24'h0, dir_f};
        out_f_offset: next_prdata = {24'h0, out_f};
        dir_g_offset: next_prdata = {24'h0, dir_g};
        out_g_offset: next_prdata = {24'h0, out_g};
        dir_h_offset: next_prdata = {24'h0, dir_h};
        out_h_offset: next_prdata = {24'h0, out_h};
        pin_in_offset: next_prdata = {8'h0, pins_sync};
        pad_dir_offset: next_prdata = {8'h0, ph_pad_oe_o, pg_pad_oe_o, pf_pad_oe_o};
        pad_pu_offset: next_prdata = {8'h0, ph_pullup_o, pg_pullup_o, pf_pullup_o};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // debug enable bit survives reset so the debug pull-ups hold through it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= ctrl_reset | (ctrl & (5'h01 << ctrl_debug_bit));
      dir_f <= port_reset;
      out_f <= port_reset;
      dir_g <= port_reset;
      out_g <= port_reset;
      dir_h <= port_reset;
      out_h <= port_reset;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      dir_f <= next_dir_f;
      out_f <= next_out_f;
      dir_g <= next_dir_g;
      out_g <= next_out_g;
      dir_h <= next_dir_h;
      out_h <= next_out_h;
      prdata <= next_prdata;
    end
  end
  assign prdata_o = prdata;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  pin_input_sync #(.width(24)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({ph_pad_i, pg_pad_i, pf_pad_i}),
    .sync_o(pins_sync)
  );

  // ----------------------------------------------------------------
  // override tables
  // ----------------------------------------------------------------
  logic [23:0] pullup_override_en, pullup_override_val, direction_override_en, direction_override_val, portvalue_override_en, portvalue_override_val, input_enable_override_en, input_enable_override_val;
  logic [23:0] port_pu, port_dir, port_val;
  logic tdo_drive;
  logic async_ext;
  assign tdo_drive = tap_shift_ir_i || tap_shift_dr_i;
  assign async_ext = timer2_async_select && ext_clock_input_select;

  always_comb begin
    pullup_override_en = '0;
    pullup_override_val = '0;
    direction_override_en = '0;
    direction_override_val = '0;
    portvalue_override_en = '0;
    portvalue_override_val = '0;
    input_enable_override_en = '0;
    input_enable_override_val = '0;
    // port f upper nibble, lower nibble left untouched
    pullup_override_en[7:4] = {4{debug_iface_enable}};
    direction_override_en[7:4] = {4{debug_iface_enable}};
    input_enable_override_en[7:4] = {4{debug_iface_enable}};
    pullup_override_val[pf_tdi] = 1'b1;
    pullup_override_val[pf_tms] = 1'b1;
    pullup_override_val[pf_tck] = 1'b1;
    direction_override_val[pf_tdo] = tdo_drive;
    portvalue_override_en[pf_tdo] = debug_iface_enable;
    portvalue_override_val[pf_tdo] = tap_tdo_i;
    // port g
    portvalue_override_en[8 + pg_t0_compare_b_out] = t0_compare_b_en_i;
    portvalue_override_val[8 + pg_t0_compare_b_out] = t0_compare_b_out_i;
    pullup_override_en[8 + pg_osc_in] = timer2_async_select;
    direction_override_en[8 + pg_osc_in] = timer2_async_select;
    input_enable_override_en[8 + pg_osc_in] = timer2_async_select;
    input_enable_override_val[8 + pg_osc_in] = ext_clock_input_select;
    pullup_override_en[8 + pg_osc_out] = async_ext;
    direction_override_en[8 + pg_osc_out] = async_ext;
    input_enable_override_en[8 + pg_osc_out] = async_ext;
    pullup_override_en[10:8] = {3{ext_memory_enable}};
    direction_override_en[10:8] = {3{ext_memory_enable}};
    direction_override_val[10:8] = 3'h7;
    portvalue_override_en[10:8] = {3{ext_memory_enable}};
    portvalue_override_val[8 + pg_ale] = ext_ale_i;
    portvalue_override_val[8 + pg_rd] = ext_rd_i;
    portvalue_override_val[8 + pg_wr] = ext_wr_i;
    // port h upper nibble; ph7 only feeds timer4
    portvalue_override_en[16 + ph_t2_compare_b_out] = t2_compare_b_en_i;
    portvalue_override_val[16 + ph_t2_compare_b_out] = t2_compare_b_out_i;
    portvalue_override_en[16 + ph_t4_compare_c_out] = t4_compare_c_en_i;
    portvalue_override_val[16 + ph_t4_compare_c_out] = t4_compare_c_out_i;
    portvalue_override_en[16 + ph_t4_compare_b_out] = t4_compare_b_en_i;
    portvalue_override_val[16 + ph_t4_compare_b_out] = t4_compare_b_out_i;
  end

  // normal port: pull-up when input and port bit high, unless globally disabled
  assign port_dir = {dir_h, dir_g, dir_f};
  assign port_val = {out_h, out_g, out_f};
  assign port_pu = ~port_dir & port_val & {24{~pullup_disable}};

  logic [23:0] pad_pu, pad_dir, pad_val, pad_ie;
  genvar i;
  generate
    for (i = 0; i < 24; i++) begin : g_cell
      pin_override_cell u_cell (
        .port_pullup_i(port_pu[i]),
        .port_dir_i(port_dir[i]),
        .port_value_i(port_val[i]),
        .port_ie_i(1'b1),
        .pullup_override_en_i(pullup_override_en[i]),
        .pullup_override_val_i(pullup_override_val[i]),
        .direction_override_en_i(direction_override_en[i]),
        .direction_override_val_i(direction_override_val[i]),
        .portvalue_override_en_i(portvalue_override_en[i]),
        .portvalue_override_val_i(portvalue_override_val[i]),
        .input_enable_override_en_i(input_enable_override_en[i]),
        .input_enable_override_val_i(input_enable_override_val[i]),
        .pullup_o(pad_pu[i]),
        .dir_o(pad_dir[i]),
        .value_o(pad_val[i]),
        .ie_o(pad_ie[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad outputs and alternate feeds
  // ----------------------------------------------------------------
  assign {ph_pullup_o, pg_pullup_o, pf_pullup_o} = pad_pu;
  assign {ph_pad_oe_o, pg_pad_oe_o, pf_pad_oe_o} = pad_dir;
  assign {ph_pad_o, pg_pad_o, pf_pad_o} = pad_val;
  assign {ph_ie_o, pg_ie_o, pf_ie_o} = pad_ie;

  // analog path is the raw pin, it never passes the digital buffer
  assign analog_in_o = pf_pad_i;
  // tck, tms, tdo, tdi synchronised for the tap logic elsewhere
  assign debug_pins_o = pins_sync[7:4];
  // oscillator input is analog in nature, so it bypasses the synchroniser
  assign timer_osc_in_pin_o = pg_pad_i[pg_osc_in];
  assign t4_count_input_o = pins_sync[16 + ph_t4] & pad_ie[16 + ph_t4];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_debug_override;
    @(posedge clk_i) debug_iface_enable |-> (pf_pad_oe_o[7] == 1'b0) && (pf_ie_o[7:4] == 4'h0);
  endproperty
  a_debug_override: assert property (p_debug_override) else $error("debug pins not freed");

  property p_tdo_tristate;
    @(posedge clk_i) debug_iface_enable && !tap_shift_ir_i && !tap_shift_dr_i
      |-> !pf_pad_oe_o[pf_tdo];
  endproperty
  a_tdo_tristate: assert property (p_tdo_tristate) else $error("data out driven outside shift");

  property p_debug_pullups;
    @(posedge clk_i) debug_iface_enable |-> pf_pullup_o[7:4] == 4'hb;
  endproperty
  a_debug_pullups: assert property (p_debug_pullups) else $error("debug pull-ups wrong");

  property p_lower_f_plain;
    @(posedge clk_i) disable iff (reset_i) pf_pad_oe_o[3:0] == dir_f[3:0] && pf_ie_o[3:0] == 4'hf;
  endproperty
  a_lower_f_plain: assert property (p_lower_f_plain) else $error("lower port f overridden");

  property p_t0_compare_b_out;
    @(posedge clk_i) t0_compare_b_en_i |-> pg_pad_o[pg_t0_compare_b_out] == t0_compare_b_out_i
      && pg_pad_oe_o[pg_t0_compare_b_out] == dir_g[pg_t0_compare_b_out];
  endproperty
  a_t0_compare_b_out: assert property (p_t0_compare_b_out) else $error("compare b not on pg5");

  property p_osc_in;
    @(posedge clk_i) timer2_async_select |-> !pg_pullup_o[pg_osc_in] && !pg_pad_oe_o[pg_osc_in]
      && pg_ie_o[pg_osc_in] == ext_clock_input_select;
  endproperty
  a_osc_in: assert property (p_osc_in) else $error("pg4 not released");

  property p_osc_out;
    @(posedge clk_i) async_ext |-> !pg_ie_o[pg_osc_out] && !pg_pad_oe_o[pg_osc_out];
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("pg3 not released");

  property p_ext_mem;
    @(posedge clk_i) ext_memory_enable |-> pg_pad_oe_o[2:0] == 3'h7 && pg_pullup_o[2:0] == 3'h0
      && pg_pad_o[2:0] == {ext_ale_i, ext_rd_i, ext_wr_i};
  endproperty
  a_ext_mem: assert property (p_ext_mem) else $error("strobes not driven");

  property p_ph_compare;
    @(posedge clk_i) t2_compare_b_en_i |-> ph_pad_o[ph_t2_compare_b_out] == t2_compare_b_out_i;
  endproperty
  a_ph_compare: assert property (p_ph_compare) else $error("ph6 compare missing");

  property p_debug_hold;
    @(posedge clk_i) debug_iface_enable && reset_i |=> debug_iface_enable;
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("debug lost in reset");

  property p_ph7_plain;
    @(posedge clk_i) ph_pad_oe_o[ph_t4] == dir_h[ph_t4] && ph_ie_o[ph_t4];
  endproperty
  a_ph7_plain: assert property (p_ph7_plain) else $error("ph7 overridden");

  property p_t4_compares;
    @(posedge clk_i) t4_compare_c_en_i && t4_compare_b_en_i
      |-> ph_pad_o[ph_t4_compare_c_out] == t4_compare_c_out_i && ph_pad_o[ph_t4_compare_b_out] == t4_compare_b_out_i
      && ph_pad_oe_o[6:4] == dir_h[6:4];
  endproperty
  a_t4_compares: assert property (p_t4_compares) else $error("timer4 compares missing");

endmodule

// >>> testbench/pad_world.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// far side: pad wires, external drivers, test clock source
// --------------------------------------------------------------
module pad_world (
  // clock
  input wire logic clk_i,
  // device pad controls {h,g,f}
  input wire logic [23:0] oe_i,
  input wire logic [23:0] o_i,
  input wire logic [23:0] pu_i,
  // external drivers
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_i,
  input wire logic tck_run_i,
  // resolved pin levels
  output logic [23:0] lvl_o
);
  logic flip = 1'b0;
  logic tck = 1'b0;
  always @(posedge clk_i) begin
    flip <= ~flip;
    tck <= tck_run_i ? ~tck : 1'b0; // clock stands still between frames
  end
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (oe_i[i]) lvl_o[i] = o_i[i];
      else if (ext_en_i[i]) lvl_o[i] = ext_i[i]; // tester steers mode select and data
      else if (pu_i[i]) lvl_o[i] = 1'b1;
      else lvl_o[i] = flip; // floating wire wanders, never a stale value
    end
    if (tck_run_i) lvl_o[4] = tck;
  end
endmodule

// >>> testbench/port_fgh_alt_function_override_tb.sv
`timescale 1ns/1ps
module port_fgh_alt_function_override_tb;
  import pin_mux_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic shir = 1'b0, shdr = 1'b0, tdo = 1'b0, tck_run = 1'b0, osc_in, t4cnt;
  logic [3:0] cmp_en = 4'h0, cmp_out = 4'h0, dbg;
  logic [2:0] mem = 3'h0;
  logic [23:0] ext_en = 24'h0, ext = 24'h0, lvl;
  logic [7:0] pf_o, pf_oe, pf_pu, pf_ie, pg_o, pg_oe, pg_pu, pg_ie, ph_o, ph_oe, ph_pu, ph_ie, ana;
  int fails = 0;
  int tests_run = 0;

  always #2.5 clk_i = ~clk_i;

  port_fgh_alt_function_override i_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tap_shift_ir_i(shir),
    .tap_shift_dr_i(shdr), .tap_tdo_i(tdo), .t0_compare_b_en_i(cmp_en[0]),
    .t0_compare_b_out_i(cmp_out[0]), .t2_compare_b_en_i(cmp_en[1]),
    .t2_compare_b_out_i(cmp_out[1]), .t4_compare_c_en_i(cmp_en[2]),
    .t4_compare_c_out_i(cmp_out[2]), .t4_compare_b_en_i(cmp_en[3]),
    .t4_compare_b_out_i(cmp_out[3]), .ext_ale_i(mem[2]), .ext_rd_i(mem[1]), .ext_wr_i(mem[0]),
    .pf_pad_i(lvl[7:0]), .pg_pad_i(lvl[15:8]), .ph_pad_i(lvl[23:16]), .pf_pad_o(pf_o),
    .pf_pad_oe_o(pf_oe), .pf_pullup_o(pf_pu), .pf_ie_o(pf_ie), .pg_pad_o(pg_o),
    .pg_pad_oe_o(pg_oe), .pg_pullup_o(pg_pu), .pg_ie_o(pg_ie), .ph_pad_o(ph_o),
    .ph_pad_oe_o(ph_oe), .ph_pullup_o(ph_pu), .ph_ie_o(ph_ie), .analog_in_o(ana),
    .debug_pins_o(dbg), .timer_osc_in_pin_o(osc_in), .t4_count_input_o(t4cnt));

  pad_world i_world (.clk_i(clk_i), .oe_i({ph_oe, pg_oe, pf_oe}), .o_i({ph_o, pg_o, pf_o}),
    .pu_i({ph_pu, pg_pu, pf_pu}), .ext_en_i(ext_en), .ext_i(ext), .tck_run_i(tck_run),
    .lvl_o(lvl));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // sample one step past the edge so combinational pads have settled
  task settle;
    @(posedge clk_i);
    #1;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
           output logic err);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic experr, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk({31'h0, e}, {31'h0, experr}, what);
    chk(q, exp, what);
  endtask
  function automatic logic [31:0] cb(input int b);
    return 32'h1 << b;
  endfunction

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_regs;
    rd(ctrl_offset, 32'h0, 1'b0, "ctrl reset");
    for (int i = 1; i < 7; i++) rd(8'(4 * i), 32'h0, 1'b0, "port reset");
    wr(pad_dir_offset, 32'hff);
    rd(pad_dir_offset, 32'h0, 1'b0, "pad dir is read only");
    rd(8'h40, 32'h0, 1'b1, "unmapped");
    rd(8'h02, 32'h0, 1'b1, "unaligned");
  endtask
  task t_portf;
    logic tck_seen;
    wr(dir_f_offset, 32'h05);
    wr(out_f_offset, 32'h0f);
    ext_en <= 24'h0000a0;
    ext <= 24'h000020;
    wr(ctrl_offset, cb(ctrl_debug_bit));
    settle;
    chk(pf_pu[7:4], 4'hb, "debug pullups");
    chk({pf_ie[7:4], pf_oe[7:4]}, 8'h00, "debug inputs");
    chk({pf_pu[3:0], pf_oe[3:0], pf_o[3:0], pf_ie[3:0]}, 16'ha5ff, "lower f");
    chk(ana, lvl[7:0], "analog from pin");
    rd(pad_pu_offset, 32'hba, 1'b0, "pullup readback");
    @(posedge clk_i);
    tck_run <= 1'b1;
    shdr <= 1'b1;
    tdo <= 1'b1;
    repeat (3) settle;
    chk({dbg[3], dbg[1]}, 2'b01, "debug pins");
    tck_seen = dbg[0];
    settle;
    chk(dbg[0] ^ tck_seen, 1'b1, "tck reaches tap");
    chk({pf_oe[pf_tdo], pf_o[pf_tdo]}, 2'b11, "tdo in shift dr");
    @(posedge clk_i);
    shdr <= 1'b0;
    shir <= 1'b1;
    tdo <= 1'b0;
    settle;
    chk({pf_oe[pf_tdo], pf_o[pf_tdo]}, 2'b10, "tdo in shift ir");
    @(posedge clk_i);
    shir <= 1'b0;
    tck_run <= 1'b0;
    settle;
    chk(pf_oe[pf_tdo], 1'b0, "tdo released");
    wr(ctrl_offset, cb(ctrl_debug_bit) | cb(ctrl_pud_bit));
    settle;
    chk(pf_pu, 8'hb0, "forced over disable");
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) settle;
    chk(pf_pu[7:4], 4'hb, "pullups in reset");
    @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ctrl_offset, cb(ctrl_debug_bit), 1'b0, "debug kept");
    wr(ctrl_offset, 32'h0);
    ext_en <= 24'h0;
    settle;
    chk({pf_pu, pf_ie}, 16'h00ff, "debug off");
  endtask
  task t_portg;
    wr(out_g_offset, 32'h1f);
    wr(dir_g_offset, 32'h00);
    cmp_en <= 4'h1;
    cmp_out <= 4'h1;
    ext_en <= 24'h001000;
    ext <= 24'h001000;
    settle;
    chk({pg_oe[pg_t0_compare_b_out], pg_o[pg_t0_compare_b_out]}, 2'b01, "t0_compare_b_out no dir");
    wr(dir_g_offset, 32'h20);
    settle;
    chk({pg_oe[pg_t0_compare_b_out], pg_o[pg_t0_compare_b_out]}, 2'b11, "t0_compare_b_out drives");
    @(posedge clk_i);
    cmp_en <= 4'h0;
    settle;
    chk(pg_o[pg_t0_compare_b_out], 1'b0, "port value back");
    wr(ctrl_offset, cb(ctrl_async_bit));
    settle;
    chk({pg_pu[4:3], pg_oe[4:3], pg_ie[4:3]}, 6'b010001, "async only");
    chk(osc_in, 1'b1, "osc input raw");
    wr(ctrl_offset, cb(ctrl_async_bit) | cb(ctrl_extclk_bit));
    settle;
    chk({pg_pu[4:3], pg_oe[4:3], pg_ie[4:3]}, 6'b000010, "async ext clk");
    wr(ctrl_offset, cb(ctrl_extclk_bit));
    settle;
    chk({pg_pu[4:3], pg_oe[4:3], pg_ie[4:3]}, 6'b110011, "ext clk only");
    wr(ctrl_offset, cb(ctrl_extmem_bit));
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      mem <= 3'(i);
      settle;
      chk({pg_oe[2:0], pg_pu[2:0], pg_o[2:0]}, {6'b111000, 3'(i)}, "strobes");
    end
    wr(ctrl_offset, 32'h0);
    settle;
    chk({pg_oe[2:0], pg_pu[2:0]}, 6'b000111, "strobes off");
  endtask
  task t_porth;
    wr(dir_h_offset, 32'h50);
    wr(out_h_offset, 32'h80);
    cmp_en <= 4'he;
    cmp_out <= 4'ha;
    ext_en <= 24'h800000;
    ext <= 24'h000000;
    settle;
    chk({ph_o[6:4], ph_oe[6:4]}, 6'b101101, "compare outs");
    chk({ph_pu[ph_t4], ph_oe[ph_t4]}, 2'b10, "ph7 normal");
    chk(ph_ie, 8'hff, "port h inputs open");
    @(posedge clk_i);
    cmp_en <= 4'h0;
    settle;
    chk(ph_o[6:4], 3'b000, "port value back");
    @(posedge clk_i);
    ext[23] <= 1'b1;
    settle;
    chk(t4cnt, 1'b0, "count input early");
    settle;
    chk(t4cnt, 1'b1, "count input");
  endtask

  // --------------------------------------------------------------
  // main and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_portf;
    t_portg;
    t_porth;
    finish_test;
  end
  // under two hundred cycles are needed; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test;
  end
endmodule
